// >>> hw/memory_access_router.sv
// Memory access router: direct program path and shared data bus
`timescale 1ns/100ps
module memory_access_router (
    // Clock and reset
    input  wire logic                                            clk_in,
    input  wire logic                                            rst_in,
    // CPU access port
    input  wire logic                                            cpu_req_in,
    input  wire logic                                            cpu_wr_in,
    input  wire logic      [router_pkg::ADDR_W-1:0]              cpu_addr_in,
    input  wire logic      [router_pkg::DATA_W-1:0]              cpu_wdata_in,
    output logic                                                 cpu_ack_out,
    output logic           [router_pkg::DATA_W-1:0]              cpu_rdata_out,
    // Program store path
    output logic                                                 rom_rd_out,
    output logic           [router_pkg::ADDR_W-1:0]              rom_addr_out,
    input  wire logic      [router_pkg::DATA_W-1:0]              rom_data_in,
    // Keyboard encoder
    input  wire logic                                            key_strobe_in,
    input  wire logic      [router_pkg::DATA_W-1:0]              key_code_in,
    // Peripheral cards by slot
    input  wire logic      [router_pkg::NUM_PERIPH-1:0]          per_req_in,
    input  wire logic      [router_pkg::NUM_PERIPH-1:0]          per_wr_in,
    input  wire logic      [router_pkg::NUM_PERIPH-1:0][13:0]    per_addr_in,
    input  wire logic      [router_pkg::NUM_PERIPH-1:0][7:0]     per_wdata_in,
    output logic           [router_pkg::NUM_PERIPH-1:0]          per_done_out,
    output logic           [router_pkg::DATA_W-1:0]              per_rdata_out,
    // Video and refresh
    output logic                                                 video_valid_out,
    output logic           [router_pkg::DATA_W-1:0]              video_code_out,
    output logic           [6:0]                                 refresh_row_out,
    // Bus monitor
    output logic                                                 bus_cycle_out,
    output logic                                                 bus_wr_out,
    output logic           [router_pkg::ADDR_W-1:0]              bus_addr_out
);
    import router_pkg::*;

    cpu_state_t          cpu_state;
    logic [ADDR_W-1:0]   cpu_addr;
    logic                cpu_wr;
    logic [DATA_W-1:0]   cpu_wdata;
    logic [7:0]          cyc_cnt;
    logic                mem_tick;
    logic [NUM_REQ-1:0]  req_vec;
    logic [NUM_REQ-1:0]  grant;
    logic [NUM_REQ-1:0]  done_src;
    logic                done_video_rd;
    logic [4:0]          ref_cnt;
    logic                ref_pend;
    logic [2:0]          vid_cnt;
    logic                vid_pend;
    logic [CHIP_W-1:0]   vid_idx;
    logic                kbd_pend;
    logic [DATA_W-1:0]   kbd_code;
    logic                kbd_written;
    logic [ADDR_W-1:0]   sel_addr;
    logic                sel_wr;
    logic [DATA_W-1:0]   sel_wdata;
    logic                ram_sel;
    logic [DATA_W-1:0]   rd_data;
    logic [DATA_W-1:0]   ram [0:RAM_BYTES-1];

    // Memory cycle divider
    always_ff @(posedge clk_in) begin
        if (rst_in || mem_tick) begin
            cyc_cnt <= 8'h00;
        end else begin
            cyc_cnt <= cyc_cnt + 8'h01;
        end
    end
    assign mem_tick = (cyc_cnt == CYC_LAST);

    // CPU access sequencer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cpu_state     <= CPU_IDLE;
            cpu_addr      <= 14'h0000;
            cpu_wr        <= 1'b0;
            cpu_wdata     <= 8'h00;
            cpu_ack_out   <= 1'b0;
            cpu_rdata_out <= 8'h00;
            rom_rd_out    <= 1'b0;
            rom_addr_out  <= 14'h0000;
        end else begin
            cpu_ack_out <= 1'b0;
            case (cpu_state)
                CPU_IDLE: begin
                    if (cpu_req_in) begin
                        cpu_addr  <= cpu_addr_in;
                        cpu_wr    <= cpu_wr_in;
                        cpu_wdata <= cpu_wdata_in;
                        if (cpu_addr_in < ROM_TOP && !cpu_wr_in) begin
                            rom_addr_out <= cpu_addr_in;
                            rom_rd_out   <= 1'b1;
                            cpu_state    <= CPU_ROM;
                        end else if (cpu_addr_in < ROM_TOP) begin
                            cpu_ack_out <= 1'b1;
                        end else begin
                            cpu_state <= CPU_BUS;
                        end
                    end
                end
                CPU_ROM: begin
                    cpu_rdata_out <= rom_data_in;
                    cpu_ack_out   <= 1'b1;
                    rom_rd_out    <= 1'b0;
                    cpu_state     <= CPU_IDLE;
                end
                CPU_BUS: begin
                    if (mem_tick && grant[REQ_CPU]) begin
                        cpu_state <= CPU_FINISH;
                    end
                end
                CPU_FINISH: begin
                    if (done_src[REQ_CPU]) begin
                        cpu_rdata_out <= rd_data;
                        cpu_ack_out   <= 1'b1;
                        cpu_state     <= CPU_IDLE;
                    end
                end
                default: begin
                    cpu_state <= CPU_IDLE;
                end
            endcase
        end
    end

    // Memory refresh and video request timers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ref_cnt  <= 5'h00;
            ref_pend <= 1'b0;
            vid_cnt  <= 3'h0;
            vid_pend <= 1'b0;
        end else if (mem_tick) begin
            ref_cnt  <= (ref_cnt == REF_LAST) ? 5'h00 : ref_cnt + 5'h01;
            vid_cnt  <= (vid_cnt == VID_LAST) ? 3'h0 : vid_cnt + 3'h1;
            ref_pend <= (ref_cnt == REF_LAST) | (ref_pend & ~grant[REQ_REFRESH]);
            vid_pend <= (vid_cnt == VID_LAST) | (vid_pend & ~grant[REQ_VIDEO]);
        end
    end

    key_capture u_key (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .key_strobe_in (key_strobe_in),
        .key_code_in   (key_code_in),
        .written_in    (kbd_written),
        .pending_out   (kbd_pend),
        .code_out      (kbd_code)
    );
    assign kbd_written = mem_tick & grant[REQ_VIDEO] & kbd_pend;

    assign req_vec = {per_req_in, vid_pend | kbd_pend, ref_pend, cpu_state == CPU_BUS};

    cycle_arbiter u_arb (
        .req_in    (req_vec),
        .grant_out (grant)
    );

    // only a granted requester drives the bus address
    always_comb begin
        sel_addr  = 14'h0000;
        sel_wr    = 1'b0;
        sel_wdata = 8'h00;
        if (grant[REQ_CPU]) begin
            sel_addr  = cpu_addr;
            sel_wr    = cpu_wr;
            sel_wdata = cpu_wdata;
        end else if (grant[REQ_VIDEO] && kbd_pend) begin
            sel_addr  = KBD_REG;
            sel_wr    = 1'b1;
            sel_wdata = kbd_code;
        end else if (grant[REQ_VIDEO]) begin
            sel_addr = DISP_BASE + {3'h0, vid_idx};
        end else begin
            for (int p = 0; p < NUM_PERIPH; p++) begin
                if (grant[REQ_PERIPH + p]) begin
                    sel_addr  = per_addr_in[p];
                    sel_wr    = per_wr_in[p];
                    sel_wdata = per_wdata_in[p];
                end
            end
        end
    end

    assign ram_sel = (sel_addr[ADDR_W-1:CHIP_W] == RAM_CARD) & ~grant[REQ_REFRESH];

    // one data memory transaction per cycle
    always_ff @(posedge clk_in) begin
        if (mem_tick && ram_sel && sel_wr) begin
            ram[sel_addr[CHIP_W-1:0]] <= sel_wdata;
        end
    end

    // program store never answers the bus
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_data <= 8'h00;
        end else if (mem_tick) begin
            rd_data <= ram_sel ? ram[sel_addr[CHIP_W-1:0]] : OPEN_BUS;
        end
    end

    // Cycle completion and bus monitor
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            done_src      <= '0;
            done_video_rd <= 1'b0;
            bus_cycle_out <= 1'b0;
            bus_wr_out    <= 1'b0;
            bus_addr_out  <= 14'h0000;
        end else begin
            done_src      <= mem_tick ? grant : '0;
            done_video_rd <= mem_tick & grant[REQ_VIDEO] & ~kbd_pend;
            bus_cycle_out <= mem_tick & (|grant) & ~grant[REQ_REFRESH];
            if (mem_tick) begin
                bus_wr_out   <= sel_wr;
                bus_addr_out <= sel_addr;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            vid_idx         <= 11'h000;
            video_valid_out <= 1'b0;
            video_code_out  <= 8'h00;
        end else begin
            if (mem_tick && grant[REQ_VIDEO] && !kbd_pend) begin
                vid_idx <= (vid_idx == DISP_LAST) ? 11'h000 : vid_idx + 11'h001;
            end
            video_valid_out <= done_video_rd;
            if (done_video_rd) begin
                video_code_out <= rd_data;
            end
        end
    end

    // Refresh row counter
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            refresh_row_out <= 7'h00;
        end else if (mem_tick && grant[REQ_REFRESH]) begin
            refresh_row_out <= refresh_row_out + 7'h01;
        end
    end

    for (genvar s = 0; s < NUM_PERIPH; s++) begin : g_slot
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                per_done_out[s] <= 1'b0;
            end else begin
                per_done_out[s] <= done_src[REQ_PERIPH + s];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            per_rdata_out <= 8'h00;
        end else if (|done_src[NUM_REQ-1:REQ_PERIPH]) begin
            per_rdata_out <= rd_data;
        end
    end

    a_one_grant: assert property (@(posedge clk_in) disable iff (rst_in)
        $onehot0(grant)) else $error("more than one grant");
    a_cpu_first: assert property (@(posedge clk_in) disable iff (rst_in)
        mem_tick && req_vec[REQ_CPU] |-> grant[REQ_CPU]) else $error("CPU not granted first");
    a_refresh_next: assert property (@(posedge clk_in) disable iff (rst_in)
        mem_tick && req_vec[REQ_REFRESH] && !req_vec[REQ_CPU] |-> grant[REQ_REFRESH])
        else $error("refresh lost priority");
    a_rom_off_bus: assert property (@(posedge clk_in) disable iff (rst_in)
        cpu_state == CPU_ROM |-> !done_src[REQ_CPU] && rom_rd_out) else $error("fetch used the bus");
    a_rom_answer: assert property (@(posedge clk_in) disable iff (rst_in)
        cpu_req_in && cpu_state == CPU_IDLE && !cpu_wr_in && cpu_addr_in < ROM_TOP
        |=> rom_rd_out ##1 cpu_ack_out && cpu_rdata_out == $past(rom_data_in))
        else $error("program fetch not answered");
    a_cpu_bus_ack: assert property (@(posedge clk_in) disable iff (rst_in)
        mem_tick && grant[REQ_CPU] |=> bus_cycle_out ##1 cpu_ack_out) else $error("bus cycle ack late");
    a_kbd_write: assert property (@(posedge clk_in) disable iff (rst_in)
        mem_tick && grant[REQ_VIDEO] && kbd_pend |-> sel_addr == KBD_REG && sel_wr && ram_sel)
        else $error("key not written to its register");
    a_video_read: assert property (@(posedge clk_in) disable iff (rst_in)
        mem_tick && grant[REQ_VIDEO] && !kbd_pend |=> ##1 video_valid_out)
        else $error("display read not delivered");
    a_req_held: assert property (@(posedge clk_in) disable iff (rst_in)
        ref_pend && !(mem_tick && grant[REQ_REFRESH]) |=> ref_pend) else $error("refresh request dropped");
    a_tick_period: assert property (@(posedge clk_in) disable iff (rst_in)
        mem_tick |=> !mem_tick [*8]) else $error("memory cycle too short");
    a_rom_fits: assert property (@(posedge clk_in) disable iff (rst_in)
        int'(ROM_TOP) >= ROM_MIN && int'(ROM_TOP) + RAM_BYTES <= MEM_BYTES) else $error("memory map too small");
endmodule // memory_access_router

// >>> inc/router_pkg.sv
// Shared constants and types for the memory access router
package router_pkg;
    // Address space
    localparam int            ADDR_W       = 14;
    localparam int            DATA_W       = 8;
    localparam int            MEM_BYTES    = 16384;
    localparam int            CHIP_W       = 11;
    localparam int            CARD_W       = ADDR_W - CHIP_W;
    localparam logic [13:0]   ROM_TOP      = 14'h1000;
    localparam int            ROM_MIN      = 2550;
    localparam logic [13:0]   RAM_BASE     = 14'h1000;
    localparam int            RAM_BYTES    = 2048;
    localparam logic [2:0]    RAM_CARD     = 3'h2;
    localparam logic [13:0]   KBD_REG      = 14'h1002;
    localparam logic [13:0]   DISP_BASE    = 14'h1030;
    localparam logic [10:0]   DISP_LAST    = 11'h7CF;
    localparam logic [7:0]    OPEN_BUS     = 8'hFF;
    // Timing
    localparam int            CLK_NS       = 10;
    localparam int            MEM_CYCLE_NS = 1300;
    localparam logic [7:0]    CYC_LAST     = 8'(MEM_CYCLE_NS / CLK_NS - 1);
    localparam int            LINE_CYCLES  = 48;
    localparam int            REF_PER_LINE = 2;
    localparam logic [4:0]    REF_LAST     = 5'(LINE_CYCLES / REF_PER_LINE - 1);
    localparam int            ROW_CYCLES   = 480;
    localparam int            ROW_READS    = 80;
    localparam logic [2:0]    VID_LAST     = 3'(ROW_CYCLES / ROW_READS - 1);
    // Requesters, index equals priority (0 highest)
    localparam int            NUM_PERIPH   = 4;
    localparam int            NUM_REQ      = 3 + NUM_PERIPH;
    localparam int            REQ_CPU      = 0;
    localparam int            REQ_REFRESH  = 1;
    localparam int            REQ_VIDEO    = 2;
    localparam int            REQ_PERIPH   = 3;
    typedef enum {CPU_IDLE, CPU_ROM, CPU_BUS, CPU_FINISH} cpu_state_t;
endpackage

// >>> hw/cycle_arbiter.sv
// Fixed priority grant of one memory cycle among requesters
`timescale 1ns/100ps
module cycle_arbiter (
    // Requests and grant
    input  wire logic [router_pkg::NUM_REQ-1:0] req_in,
    output logic      [router_pkg::NUM_REQ-1:0] grant_out
);
    import router_pkg::*;

    logic [NUM_REQ-1:0] higher;

    assign higher[0] = 1'b0;
    for (genvar g = 1; g < NUM_REQ; g++) begin : g_chain
        assign higher[g] = higher[g-1] | req_in[g-1];
    end
    assign grant_out = req_in & ~higher;
endmodule // cycle_arbiter

// >>> hw/key_capture.sv
// Keyboard strobe synchroniser and character latch
`timescale 1ns/100ps
module key_capture (
    // Clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          rst_in,
    // Encoder pins
    input  wire logic                          key_strobe_in,
    input  wire logic [router_pkg::DATA_W-1:0] key_code_in,
    // Memory side
    input  wire logic                          written_in,
    output logic                               pending_out,
    output logic      [router_pkg::DATA_W-1:0] code_out
);
    import router_pkg::*;

    logic [2:0]        strobe_sync;
    logic [DATA_W-1:0] code_s1;
    logic [DATA_W-1:0] code_s2;
    logic [DATA_W-1:0] code_s3;
    logic              strobe_level;
    logic              key_rise;

    // Three stage synchronisers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            strobe_sync <= 3'h0;
            code_s1     <= 8'h00;
            code_s2     <= 8'h00;
            code_s3     <= 8'h00;
        end else begin
            strobe_sync <= {strobe_sync[1:0], key_strobe_in};
            code_s1     <= key_code_in;
            code_s2     <= code_s1;
            code_s3     <= code_s2;
        end
    end

    assign key_rise = strobe_sync[1] & strobe_sync[2] & ~strobe_level;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            strobe_level <= 1'b0;
        end else if (strobe_sync[1] == strobe_sync[2]) begin
            strobe_level <= strobe_sync[2];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            code_out    <= 8'h00;
            pending_out <= 1'b0;
        end else begin
            if (key_rise) begin
                code_out <= code_s3;
            end
            pending_out <= key_rise | (pending_out & ~written_in);
        end
    end
endmodule // key_capture

// >>> bench/program_store_model.sv
// Program store model behind the direct fetch path
`timescale 1ns/100ps
module program_store_model (
    // Clock
    input  wire logic                          clk_in,
    // Fetch path
    input  wire logic                          rom_rd_in,
    input  wire logic [router_pkg::ADDR_W-1:0] rom_addr_in,
    output logic      [router_pkg::DATA_W-1:0] rom_data_out
);
    import router_pkg::*;
    logic [DATA_W-1:0] junk = 8'h00;
    // Released data lines change every cycle
    always @(posedge clk_in) begin
        junk <= junk + 8'h3B;
    end
    assign rom_data_out = rom_rd_in ? (rom_addr_in[7:0] ^ 8'hA5) : junk;
endmodule // program_store_model

// >>> bench/memory_access_router_bench.sv
// Self-checking bench for the memory access router
`timescale 1ns/100ps
module memory_access_router_bench;
    import router_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, cpu_req_in = 1'b0, cpu_wr_in = 1'b0, key_strobe_in = 1'b0;
    logic [13:0] cpu_addr_in = '0, rom_addr_out, bus_addr_out;
    logic [7:0] cpu_wdata_in = '0, key_code_in = '0, cpu_rdata_out, rom_data_in, per_rdata_out, video_code_out;
    logic [3:0] per_req_in = '0, per_wr_in = '0, per_done_out, per_seen;
    logic [3:0][13:0] per_addr_in = '0;
    logic [3:0][7:0] per_wdata_in = '0;
    logic cpu_ack_out, rom_rd_out, video_valid_out, bus_cycle_out, bus_wr_out;
    logic [6:0] refresh_row_out;
    int bad_count = 0, cmp_count = 0, rom_hits, bus_hits;
    always #5 clk_in = ~clk_in;
    memory_access_router dut (.clk_in(clk_in), .rst_in(rst_in), .cpu_req_in(cpu_req_in), .cpu_wr_in(cpu_wr_in),
        .cpu_addr_in(cpu_addr_in), .cpu_wdata_in(cpu_wdata_in), .cpu_ack_out(cpu_ack_out),
        .cpu_rdata_out(cpu_rdata_out), .rom_rd_out(rom_rd_out), .rom_addr_out(rom_addr_out),
        .rom_data_in(rom_data_in), .key_strobe_in(key_strobe_in), .key_code_in(key_code_in),
        .per_req_in(per_req_in), .per_wr_in(per_wr_in), .per_addr_in(per_addr_in), .per_wdata_in(per_wdata_in),
        .per_done_out(per_done_out), .per_rdata_out(per_rdata_out), .video_valid_out(video_valid_out),
        .video_code_out(video_code_out), .refresh_row_out(refresh_row_out), .bus_cycle_out(bus_cycle_out),
        .bus_wr_out(bus_wr_out), .bus_addr_out(bus_addr_out));
    program_store_model store (.clk_in(clk_in), .rom_rd_in(rom_rd_out), .rom_addr_in(rom_addr_out),
        .rom_data_out(rom_data_in));
    task automatic report_and_stop();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic timeout();
        bad_count++;
        report_and_stop();
    endtask
    // CPU access; lat counts edges from taking edge to ack edge, both included
    task automatic cpu_access(input logic wr, input logic [13:0] addr, input logic [7:0] wdata,
                              output logic [7:0] rdata, output int lat);
        @(negedge clk_in);
        cpu_req_in = 1'b1;
        cpu_wr_in = wr;
        cpu_addr_in = addr;
        cpu_wdata_in = wdata;
        @(negedge clk_in);
        cpu_req_in = 1'b0;
        rom_hits = 0;
        bus_hits = 0;
        per_seen = '0;
        // First look is half a cycle after the taking edge
        for (lat = 1; lat < 300; lat++) begin
            rom_hits += int'(rom_rd_out === 1'b1);
            bus_hits += int'(bus_cycle_out === 1'b1);
            per_seen = per_seen | per_done_out;
            if (cpu_ack_out === 1'b1) break;
            @(negedge clk_in);
        end
        if (lat == 300) timeout();
        rdata = cpu_rdata_out;
    endtask
    task automatic per_access(input int s, input logic wr, input logic [13:0] addr, input logic [7:0] wdata,
                              output logic [7:0] rdata);
        int n;
        @(negedge clk_in);
        per_req_in[s] = 1'b1;
        per_wr_in[s] = wr;
        per_addr_in[s] = addr;
        per_wdata_in[s] = wdata;
        // request held until its cycle completes
        for (n = 0; n < 800; n++) begin
            @(negedge clk_in);
            if (per_done_out[s] === 1'b1) break;
        end
        per_req_in[s] = 1'b0;
        if (n == 800) timeout();
        rdata = per_rdata_out;
    endtask
    task automatic sc_rom_fetch();
        logic [7:0] d;
        int lat;
        cpu_access(1'b0, 14'h0123, 8'h00, d, lat);
        check(d, 16'h23 ^ 16'hA5);
        check(16'(lat), 16'h2);
        check(16'(rom_hits), 16'h1);
        check(16'(bus_hits), 16'h0);
        check(rom_addr_out, 16'h0123);
        // Write to program store is acknowledged and dropped
        cpu_access(1'b1, 14'h0123, 8'h5A, d, lat);
        check(16'(lat), 16'h1);
        check(16'(rom_hits + bus_hits), 16'h0);
    endtask
    task automatic sc_ram_cpu();
        logic [13:0] a [4] = '{14'h1000, 14'h17FF, 14'h2005, 14'h3FFF};
        logic [7:0] w [4] = '{8'h5A, 8'hC3, 8'h77, 8'h18};
        logic [7:0] e [4] = '{8'h5A, 8'hC3, 8'hFF, 8'hFF};
        logic [7:0] d;
        int lat;
        for (int i = 0; i < 4; i++) begin
            cpu_access(1'b1, a[i], w[i], d, lat);
            check({bus_wr_out, 1'b0, bus_addr_out}, {2'b10, a[i]});
        end
        for (int i = 0; i < 4; i++) begin
            cpu_access(1'b0, a[i], 8'h00, d, lat);
            check(d, e[i]);
            check(16'(bus_hits), 16'h1);
        end
    endtask
    task automatic sc_periph();
        logic [7:0] d;
        int lat;
        per_access(1, 1'b0, 14'h0010, 8'h00, d);
        check(d, 16'hFF);
        per_access(3, 1'b1, 14'h1200, 8'h96, d);
        per_access(0, 1'b0, 14'h1200, 8'h00, d);
        check(d, 16'h96);
        cpu_access(1'b0, 14'h1200, 8'h00, d, lat);
        check(d, 16'h96);
    endtask
    task automatic sc_concurrent();
        logic [7:0] d;
        logic [3:0] seen = '0;
        int lat;
        @(negedge clk_in);
        per_req_in[2] = 1'b1;
        per_wr_in[2] = 1'b1;
        per_addr_in[2] = 14'h1100;
        per_wdata_in[2] = 8'hE1;
        for (int i = 0; i < 400 && seen[2] !== 1'b1; i++) begin
            cpu_access(1'b0, 14'(i), 8'h00, d, lat);
            seen = seen | per_seen;
            check(16'(lat), 16'h2);
        end
        per_req_in[2] = 1'b0;
        check(seen[2], 1'b1);
        cpu_access(1'b0, 14'h1100, 8'h00, d, lat);
        check(d, 16'hE1);
    endtask
    task automatic sc_priority();
        logic [7:0] d;
        int lat, t0 = 0, t3 = 0;
        @(negedge clk_in);
        per_req_in = 4'b1001;
        per_wr_in = 4'b0000;
        per_addr_in[0] = 14'h1000;
        per_addr_in[3] = 14'h1000;
        cpu_access(1'b0, 14'h1001, 8'h00, d, lat);
        check(per_seen, 4'h0);
        for (int n = 1; n < 1000 && per_req_in !== 4'b0000; n++) begin
            @(negedge clk_in);
            if (per_done_out[0] === 1'b1) begin
                per_req_in[0] = 1'b0;
                t0 = n;
            end
            if (per_done_out[3] === 1'b1) begin
                per_req_in[3] = 1'b0;
                t3 = n;
            end
        end
        if (per_req_in !== 4'b0000) timeout();
        check(t0 < t3, 1'b1);
        check(16'((t3 - t0) % 130), 16'h0);
    endtask
    task automatic sc_keyboard();
        logic [7:0] d;
        int n, lat;
        @(negedge clk_in);
        key_code_in = 8'h4B;
        key_strobe_in = 1'b1;
        repeat (6) @(negedge clk_in);
        key_strobe_in = 1'b0;
        key_code_in = 8'hB4;
        // latched code written over the bus
        for (n = 0; n < 3000; n++) begin
            @(negedge clk_in);
            if (bus_cycle_out === 1'b1 && bus_wr_out === 1'b1 && bus_addr_out === KBD_REG) break;
        end
        if (n == 3000) timeout();
        cpu_access(1'b0, KBD_REG, 8'h00, d, lat);
        check(d, 16'h4B);
    endtask
    task automatic sc_video();
        logic [13:0] first;
        logic [7:0] d;
        int n, lat;
        for (int k = 0; k < 2; k++) begin
            for (n = 0; n < 2000; n++) begin
                @(negedge clk_in);
                if (video_valid_out === 1'b1) break;
            end
            if (n == 2000) timeout();
            if (k == 0) begin
                first = bus_addr_out;
                // plant a known code at the next scan location
                cpu_access(1'b1, first + 14'h1, 8'h3C, d, lat);
            end
        end
        check(video_code_out, 16'h3C);
        check(bus_wr_out, 1'b0);
        check(bus_addr_out >= DISP_BASE && bus_addr_out <= 14'h17FF, 1'b1);
        check(bus_addr_out, first + 14'h1);
    endtask
    task automatic sc_refresh();
        logic [6:0] r0;
        int n;
        r0 = refresh_row_out;
        for (n = 0; n < 3400; n++) begin
            @(negedge clk_in);
            if (refresh_row_out !== r0) break;
        end
        if (n == 3400) timeout();
        check(refresh_row_out, 7'(r0 + 7'h1));
        check(bus_cycle_out, 1'b0);
    endtask
    initial begin
        repeat (12) @(negedge clk_in);
        rst_in = 1'b0;
        sc_rom_fetch();
        sc_ram_cpu();
        sc_periph();
        sc_concurrent();
        sc_priority();
        sc_keyboard();
        sc_video();
        sc_refresh();
        report_and_stop();
    end
endmodule // memory_access_router_bench
